//--- hw/analog_cond_pkg.sv
package analog_cond_pkg;

	// data widths
	localparam int MV_W     = 16;
	localparam int SAMPLE_W = 17;
	localparam int FIFO_DEPTH = 16;

	// parameter addresses
	localparam logic [15:0] ADDR_PRIMARY_VOLT   = 16'h0902;
	localparam logic [15:0] ADDR_SECONDARY_VOLT = 16'h090A;
	localparam logic [15:0] ADDR_DEAD_WINDOW    = 16'h0912;
	localparam logic [15:0] ADDR_INPUT_OFFSET   = 16'h0916;
	localparam logic [15:0] ADDR_MAX_SPEED      = 16'h1204;
	localparam logic [15:0] ADDR_CURRENT_SCALE  = 16'h2006;
	localparam logic [15:0] ADDR_SPEED_SCALE    = 16'h2106;

	// reset values
	localparam logic [15:0] RST_DEAD_WINDOW   = 16'h0000;
	localparam logic [15:0] RST_INPUT_OFFSET  = 16'h0000;
	localparam logic [15:0] RST_CURRENT_SCALE = 16'h012C;
	localparam logic [15:0] RST_SPEED_SCALE   = 16'h0BB8;
	localparam logic [15:0] RST_MAX_SPEED     = 16'h3390;

	// value ranges
	localparam logic signed [15:0] INPUT_MV_MAX = 16'sh2710;
	localparam logic signed [15:0] OFFSET_MAX   = 16'sh1388;
	localparam logic [15:0]        WINDOW_MAX   = 16'h03E8;
	localparam logic signed [15:0] SCALE_MAX    = 16'sh7530;
	localparam logic [15:0]        SPEED_MAX    = 16'h3390;

	// millivolts at full scale, the divisor of the setpoint
	localparam logic signed [31:0] FULL_SCALE_MV = 32'sh0000_2710;

	// sample word layout
	localparam int SAMPLE_CH_BIT = 16;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CALC = 3'b010,
		ST_SEND = 3'b100
	} cond_state_t;

endpackage

//--- hw/sample_fifo_if.sv
`timescale 1ns/1ns
interface sample_fifo_if #(
	parameter int WIDTH = 17
);
	logic             wr_valid;
	logic             wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic             rd_valid;
	logic             rd_ready;
	logic [WIDTH-1:0] rd_data;

	modport fifo (
		input  wr_valid,
		output wr_ready,
		input  wr_data,
		output rd_valid,
		input  rd_ready,
		output rd_data
	);
	modport user (
		output wr_valid,
		input  wr_ready,
		output wr_data,
		input  rd_valid,
		output rd_ready,
		input  rd_data
	);
endinterface

//--- hw/sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// both sides
	sample_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    wp_nxt;
	logic [AW-1:0]    rp_r;
	logic [AW-1:0]    rp_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	// full and empty come straight from the count
	assign port.wr_ready = (cnt_r != (AW+1)'(DEPTH));
	assign port.rd_valid = (cnt_r != '0);
	assign port.rd_data  = mem_r[rp_r];
	assign push = port.wr_valid && port.wr_ready;
	assign pop  = port.rd_valid && port.rd_ready;

	// pointers wrap at the depth, which need not be a power of two
	always_comb begin
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// storage needs no reset, only the pointers and the count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= port.wr_data;
		end
		if (sys_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

//--- hw/analog_input_conditioning.sv
`timescale 1ns/1ns
//Contract
//- each channel spans -10 V to +10 V as signed 16-bit millivolts
//- primary readback is read-only signed mV, clamped to +-10000
//- secondary channel has its own read-only mV readback, same range
//- primary readback and setpoints use corrected voltage, not the raw sample
//- writable offset -5000..5000 mV added to primary sample, resets zero
//- dead window 0..1000 mV, default 0, forces small magnitudes to zero
//- offset is added before the dead window comparison
//- corrected primary voltage feeds current or speed control reference
//- current scale -30000..30000, default 300, setpoint at +10 V
//- speed scale -30000..30000, default 3000, setpoint at +10 V
//- a negative scale inverts the setpoint polarity
//- speed setpoint is clamped to the maximum speed limit
//- maximum speed is unsigned rpm up to 13200, default motor maximum
module analog_input_conditioning #(
	parameter logic [15:0] MOTOR_MAX_SPEED = analog_cond_pkg::RST_MAX_SPEED,
	parameter int          FIFO_DEPTH      = analog_cond_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// converter sample stream
	input  wire logic               adc_valid,
	output wire logic               adc_ready,
	input  wire logic               adc_channel,
	input  wire logic signed [15:0] adc_mv,
	// parameter port
	input  wire logic        [15:0] par_addr,
	input  wire logic               par_wr_en,
	input  wire logic               par_rd_en,
	input  wire logic        [15:0] par_wdata,
	output logic             [15:0] par_rdata,
	output logic                    par_rd_valid,
	output logic                    par_err,
	// setpoint stream to the control loops
	output wire logic               sp_valid,
	input  wire logic               sp_ready,
	output logic signed      [15:0] reference_mv,
	output logic signed      [15:0] current_setpoint,
	output logic signed      [15:0] speed_setpoint
);

	// clamp a wide signed value into a symmetric signed range
	function automatic logic signed [15:0] clamp_sym(
		input logic signed [31:0] v,
		input logic signed [15:0] lim
	);
		logic signed [31:0] hi;
		hi = 32'(lim);
		if (v > hi) begin
			clamp_sym = lim;
		end else if (v < -hi) begin
			clamp_sym = -lim;
		end else begin
			clamp_sym = 16'(v);
		end
	endfunction

	// sample buffer between converter and arithmetic
	sample_fifo_if #(.WIDTH(analog_cond_pkg::SAMPLE_W)) fq ();

	sample_fifo #(
		.WIDTH (analog_cond_pkg::SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (fq.fifo)
	);

	// the converter stalls once the buffer is full
	// the buffer absorbs bursts while a slow consumer holds a setpoint;
	// a sample is never dropped, the converter must hold it instead
	assign fq.wr_valid = adc_valid;
	assign fq.wr_data  = {adc_channel, adc_mv};
	assign adc_ready   = fq.wr_ready;

	// settings
	logic        [15:0] win_r;
	logic        [15:0] win_nxt;
	logic signed [15:0] offset_r;
	logic signed [15:0] offset_nxt;
	logic signed [15:0] i_scale_r;
	logic signed [15:0] i_scale_nxt;
	logic signed [15:0] n_scale_r;
	logic signed [15:0] n_scale_nxt;
	logic        [15:0] nmax_r;
	logic        [15:0] nmax_nxt;

	// readbacks and pipeline
	logic signed [15:0] prim_r;
	logic signed [15:0] prim_nxt;
	logic signed [15:0] sec_r;
	logic signed [15:0] sec_nxt;
	logic signed [15:0] sample_r;
	logic signed [15:0] sample_nxt;
	logic signed [15:0] cur_r;
	logic signed [15:0] cur_nxt;
	logic signed [15:0] spd_r;
	logic signed [15:0] spd_nxt;
	analog_cond_pkg::cond_state_t state_r;
	analog_cond_pkg::cond_state_t state_nxt;

	// parameter port answers
	logic        [15:0] rdata_nxt;
	logic               rvalid_nxt;
	logic               err_nxt;

	// arithmetic terms
	logic signed [15:0] in_lim;
	logic signed [15:0] sec_lim;
	logic signed [15:0] with_off;
	logic signed [15:0] magnitude;
	logic signed [15:0] corrected;
	logic signed [31:0] i_prod;
	logic signed [31:0] n_prod;
	logic signed [15:0] n_raw;
	logic signed [15:0] nmax_s;
	logic signed [15:0] wval;

	assign wval   = $signed(par_wdata);
	assign nmax_s = $signed(nmax_r);

	// input range limits on both channels, one limiter per channel
	// the converter may overshoot the span, so the limit comes first
	logic signed [15:0] ch_raw [2];
	logic signed [15:0] ch_lim [2];
	assign ch_raw[0] = sample_r;
	assign ch_raw[1] = $signed(fq.rd_data[15:0]);
	for (genvar ch = 0; ch < 2; ch++) begin : g_lim
		assign ch_lim[ch] = clamp_sym(32'(ch_raw[ch]), analog_cond_pkg::INPUT_MV_MAX);
	end
	assign in_lim  = ch_lim[0];
	assign sec_lim = ch_lim[1];

	// offset first, then the window around zero of the shifted value
	// the shifted value is limited again so the readback keeps its range
	// the window edge itself counts as inside and reads as zero
	assign with_off  = clamp_sym(32'(in_lim) + 32'(offset_r),
		analog_cond_pkg::INPUT_MV_MAX);
	assign magnitude = with_off[15] ? -with_off : with_off;
	assign corrected = ($unsigned(magnitude) <= win_r) ? '0 : with_off;

	// linear scaling; division truncates toward zero, so inversion is exact
	// products stay within 32 bits: 10000 times 30000 is well below 2^31
	// the extra clamp never acts: even at the scale limits the quotient is at most 30000
	assign i_prod = (32'(corrected) * 32'(i_scale_r)) / analog_cond_pkg::FULL_SCALE_MV;
	assign n_prod = (32'(corrected) * 32'(n_scale_r)) / analog_cond_pkg::FULL_SCALE_MV;
	assign n_raw  = clamp_sym(n_prod, analog_cond_pkg::SCALE_MAX);

	// pipeline: pop a sample, compute, hold the result until taken
	// secondary samples are absorbed in idle without a setpoint, so a stream of them
	// stalls while a primary sample is in ST_CALC or ST_SEND, and longer while its consumer is not ready
	// limitation: a primary sample costs at least three cycles
	always_comb begin
		state_nxt  = state_r;
		sample_nxt = sample_r;
		prim_nxt   = prim_r;
		sec_nxt    = sec_r;
		cur_nxt    = cur_r;
		spd_nxt    = spd_r;
		case (state_r)
			analog_cond_pkg::ST_IDLE: begin
				if (fq.rd_valid) begin
					if (fq.rd_data[analog_cond_pkg::SAMPLE_CH_BIT]) begin
						sec_nxt = sec_lim;
					end else begin
						sample_nxt = $signed(fq.rd_data[15:0]);
						state_nxt  = analog_cond_pkg::ST_CALC;
					end
				end
			end
			analog_cond_pkg::ST_CALC: begin
				prim_nxt = corrected;
				cur_nxt  = clamp_sym(i_prod, analog_cond_pkg::SCALE_MAX);
				spd_nxt  = clamp_sym(32'(n_raw), nmax_s);
				state_nxt = analog_cond_pkg::ST_SEND;
			end
			analog_cond_pkg::ST_SEND: begin
				if (sp_ready) begin
					state_nxt = analog_cond_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = analog_cond_pkg::ST_IDLE;
			end
		endcase
	end

	// a waiting consumer holds the pipeline, which backs up the buffer
	assign fq.rd_ready = (state_r == analog_cond_pkg::ST_IDLE);
	assign sp_valid    = (state_r == analog_cond_pkg::ST_SEND);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r  <= analog_cond_pkg::ST_IDLE;
			sample_r <= '0;
			prim_r   <= '0;
			sec_r    <= '0;
			cur_r    <= '0;
			spd_r    <= '0;
		end else begin
			state_r  <= state_nxt;
			sample_r <= sample_nxt;
			prim_r   <= prim_nxt;
			sec_r    <= sec_nxt;
			cur_r    <= cur_nxt;
			spd_r    <= spd_nxt;
		end
	end

	assign reference_mv     = prim_r;
	assign current_setpoint = cur_r;
	assign speed_setpoint   = spd_r;

	// writes: out-of-range values are refused whole rather than clipped
	// clipping would hide a software fault; the error pulse reports it
	// and the old setting keeps working meanwhile
	always_comb begin
		win_nxt     = win_r;
		offset_nxt  = offset_r;
		i_scale_nxt = i_scale_r;
		n_scale_nxt = n_scale_r;
		nmax_nxt    = nmax_r;
		err_nxt     = 1'b0;
		if (par_wr_en) begin
			case (par_addr)
				analog_cond_pkg::ADDR_DEAD_WINDOW: begin
					if (par_wdata <= analog_cond_pkg::WINDOW_MAX) begin
						win_nxt = par_wdata;
					end else begin
						err_nxt = 1'b1;
					end
				end
				analog_cond_pkg::ADDR_INPUT_OFFSET: begin
					if (wval <= analog_cond_pkg::OFFSET_MAX && wval >= -analog_cond_pkg::OFFSET_MAX) begin
						offset_nxt = wval;
					end else begin
						err_nxt = 1'b1;
					end
				end
				analog_cond_pkg::ADDR_CURRENT_SCALE: begin
					if (wval <= analog_cond_pkg::SCALE_MAX && wval >= -analog_cond_pkg::SCALE_MAX) begin
						i_scale_nxt = wval;
					end else begin
						err_nxt = 1'b1;
					end
				end
				analog_cond_pkg::ADDR_SPEED_SCALE: begin
					if (wval <= analog_cond_pkg::SCALE_MAX && wval >= -analog_cond_pkg::SCALE_MAX) begin
						n_scale_nxt = wval;
					end else begin
						err_nxt = 1'b1;
					end
				end
				analog_cond_pkg::ADDR_MAX_SPEED: begin
					if (par_wdata <= analog_cond_pkg::SPEED_MAX) begin
						nmax_nxt = par_wdata;
					end else begin
						err_nxt = 1'b1;
					end
				end
				// readbacks are read-only, unknown addresses are errors
				default: begin
					err_nxt = 1'b1;
				end
			endcase
		end
	end

	// reads: answer one cycle later, unmapped reads give zero and an error
	// read data is zero outside the answer cycle, so a wide or-bus
	// of several blocks may merge answers without extra muxing
	always_comb begin
		rdata_nxt  = '0;
		rvalid_nxt = par_rd_en;
		if (par_rd_en) begin
			case (par_addr)
				analog_cond_pkg::ADDR_PRIMARY_VOLT:   rdata_nxt = prim_r;
				analog_cond_pkg::ADDR_SECONDARY_VOLT: rdata_nxt = sec_r;
				analog_cond_pkg::ADDR_DEAD_WINDOW:    rdata_nxt = win_r;
				analog_cond_pkg::ADDR_INPUT_OFFSET:   rdata_nxt = offset_r;
				analog_cond_pkg::ADDR_CURRENT_SCALE:  rdata_nxt = i_scale_r;
				analog_cond_pkg::ADDR_SPEED_SCALE:    rdata_nxt = n_scale_r;
				analog_cond_pkg::ADDR_MAX_SPEED:      rdata_nxt = nmax_r;
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	// a bad read raises the same error pulse as a bad write
	logic rd_bad;
	always_comb begin
		rd_bad = 1'b0;
		if (par_rd_en) begin
			case (par_addr)
				analog_cond_pkg::ADDR_PRIMARY_VOLT,
				analog_cond_pkg::ADDR_SECONDARY_VOLT,
				analog_cond_pkg::ADDR_DEAD_WINDOW,
				analog_cond_pkg::ADDR_INPUT_OFFSET,
				analog_cond_pkg::ADDR_CURRENT_SCALE,
				analog_cond_pkg::ADDR_SPEED_SCALE,
				analog_cond_pkg::ADDR_MAX_SPEED: rd_bad = 1'b0;
				default: begin
					rd_bad = 1'b1;
				end
			endcase
		end
	end

	// settings survive everything but reset
	// the answer registers share this process since they reset together
	// and are clocked on the same edge as the settings themselves
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			win_r        <= analog_cond_pkg::RST_DEAD_WINDOW;
			offset_r     <= analog_cond_pkg::RST_INPUT_OFFSET;
			i_scale_r    <= analog_cond_pkg::RST_CURRENT_SCALE;
			n_scale_r    <= analog_cond_pkg::RST_SPEED_SCALE;
			nmax_r       <= MOTOR_MAX_SPEED;
			par_rdata    <= '0;
			par_rd_valid <= 1'b0;
			par_err      <= 1'b0;
		end else begin
			win_r        <= win_nxt;
			offset_r     <= offset_nxt;
			i_scale_r    <= i_scale_nxt;
			n_scale_r    <= n_scale_nxt;
			nmax_r       <= nmax_nxt;
			par_rdata    <= rdata_nxt;
			par_rd_valid <= rvalid_nxt;
			par_err      <= err_nxt || rd_bad;
		end
	end

endmodule

//--- tb/analog_cond_asserts.sv
`timescale 1ns/1ns
// port-level checks; a stalled setpoint must stand still until taken
module analog_cond_asserts #(
	parameter logic [15:0] MOTOR_MAX_SPEED = 16'h3390
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               sys_rst,
	// parameter port
	input wire logic        [15:0] par_addr,
	input wire logic               par_wr_en,
	input wire logic               par_rd_en,
	input wire logic        [15:0] par_wdata,
	input wire logic        [15:0] par_rdata,
	input wire logic               par_rd_valid,
	input wire logic               par_err,
	// setpoint stream
	input wire logic               sp_valid,
	input wire logic               sp_ready,
	input wire logic signed [15:0] reference_mv,
	input wire logic signed [15:0] current_setpoint,
	input wire logic signed [15:0] speed_setpoint
);
	localparam int SPD = int'(MOTOR_MAX_SPEED);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// a read request and a setpoint offer left waiting
	sequence rd_req; par_rd_en; endsequence
	sequence sp_stall; sp_valid && !sp_ready; endsequence
	rd_answer_a: assert property (rd_req |=> par_rd_valid)
		else $error("read not answered");
	rd_quiet_a: assert property (!par_rd_en |=> !par_rd_valid && par_rdata == 16'h0)
		else $error("stray read data");
	ro_refuse_a: assert property (par_wr_en && (par_addr == 16'h0902 || par_addr == 16'h090A) |=> par_err)
		else $error("readback write not refused");
	win_refuse_a: assert property (par_wr_en && par_addr == 16'h0912 && par_wdata > 16'h03E8 |=> par_err)
		else $error("wide window not refused");
	sp_hold_a: assert property (sp_stall |=> sp_valid && $stable(reference_mv) && $stable(current_setpoint)
		&& $stable(speed_setpoint)) else $error("setpoint moved while stalled");
	sp_drop_a: assert property (sp_valid && sp_ready |=> !sp_valid)
		else $error("setpoint offered twice");
	ref_range_a: assert property (sp_valid |-> reference_mv <= 16'sh2710 && reference_mv >= -16'sh2710)
		else $error("reference out of range");
	speed_clamp_a: assert property (sp_valid |-> speed_setpoint <= SPD && speed_setpoint >= -SPD)
		else $error("speed above limit");
endmodule

bind analog_input_conditioning analog_cond_asserts #(.MOTOR_MAX_SPEED(MOTOR_MAX_SPEED)) chk_u (
	.clk(clk), .sys_rst(sys_rst), .par_addr(par_addr), .par_wr_en(par_wr_en), .par_rd_en(par_rd_en),
	.par_wdata(par_wdata), .par_rdata(par_rdata), .par_rd_valid(par_rd_valid), .par_err(par_err),
	.sp_valid(sp_valid), .sp_ready(sp_ready), .reference_mv(reference_mv),
	.current_setpoint(current_setpoint), .speed_setpoint(speed_setpoint));

//--- tb/adc_model.sv
`timescale 1ns/1ns
// converter source: queued samples in order, each held until taken
module adc_model (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// sample stream
	input  wire logic               adc_ready,
	output logic                    adc_valid = 1'b0,
	output logic                    adc_channel = 1'b0,
	output logic signed [15:0]      adc_mv = 16'sh0
);
	logic [16:0] q[$];
	// one word per sample: channel bit over millivolts
	task automatic send(input logic ch, input logic [15:0] mv);
		q.push_back({ch, mv});
	endtask
	// idle lines toggle so a stale value never passes for data
	always @(posedge clk) begin
		if (!sys_rst && adc_valid && adc_ready)
			void'(q.pop_front());
		if (!sys_rst && q.size() != 0) begin
			adc_valid <= 1'b1;
			{adc_channel, adc_mv} <= q[0];
		end else begin
			adc_valid <= 1'b0;
			adc_channel <= ~adc_channel;
			adc_mv <= ~adc_mv;
		end
	end
endmodule

//--- tb/analog_input_conditioning_test.sv
`timescale 1ns/1ns
module analog_input_conditioning_test;
	// design inputs and outputs
	logic               clk = 1'b0;
	logic               sys_rst = 1'b1;
	logic               adc_valid;
	logic               adc_ready;
	logic               adc_channel;
	logic signed [15:0] adc_mv;
	logic        [15:0] par_addr = 16'h0;
	logic               par_wr_en = 1'b0;
	logic               par_rd_en = 1'b0;
	logic        [15:0] par_wdata = 16'h0;
	logic        [15:0] par_rdata;
	logic               par_rd_valid;
	logic               par_err;
	logic               sp_valid;
	logic               sp_ready = 1'b1;
	logic signed [15:0] reference_mv;
	logic signed [15:0] current_setpoint;
	logic signed [15:0] speed_setpoint;
	int                 n_mismatch = 0;
	int                 comparisons = 0;

	always #4 clk = ~clk;

	analog_input_conditioning dut_u (.clk(clk), .sys_rst(sys_rst), .adc_valid(adc_valid), .adc_ready(adc_ready),
		.adc_channel(adc_channel), .adc_mv(adc_mv), .par_addr(par_addr), .par_wr_en(par_wr_en),
		.par_rd_en(par_rd_en), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rd_valid(par_rd_valid),
		.par_err(par_err), .sp_valid(sp_valid), .sp_ready(sp_ready), .reference_mv(reference_mv),
		.current_setpoint(current_setpoint), .speed_setpoint(speed_setpoint));
	adc_model adc_u (.clk(clk), .sys_rst(sys_rst), .adc_ready(adc_ready), .adc_valid(adc_valid),
		.adc_channel(adc_channel), .adc_mv(adc_mv));

	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// parameter write, judged on the refusal pulse
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
		@(posedge clk);
		par_addr <= a;
		par_wdata <= d;
		par_wr_en <= 1'b1;
		@(posedge clk);
		par_wr_en <= 1'b0;
		#1;
		check({15'h0, par_err}, {15'h0, e});
	endtask
	// parameter read, data and refusal judged one cycle on
	task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic e);
		@(posedge clk);
		par_addr <= a;
		par_rd_en <= 1'b1;
		@(posedge clk);
		par_rd_en <= 1'b0;
		#1;
		check({15'h0, par_rd_valid}, 16'h1);
		check(par_rdata, exp);
		check({15'h0, par_err}, {15'h0, e});
	endtask
	function automatic int clampi(input int v, input int lim);
		return v > lim ? lim : (v < -lim ? -lim : v);
	endfunction
	// bounded wait for the next setpoint offer
	task automatic wait_sp();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (sp_valid !== 1'b1 && n < 60);
		check({15'h0, sp_valid}, 16'h1);
	endtask
	// program the chain, send one primary sample, judge all outputs
	task automatic run_case(input int raw, off, win, isc, nsc, mx);
		int v;
		wr(16'h0916, 16'(off), 1'b0);
		wr(16'h0912, 16'(win), 1'b0);
		wr(16'h2006, 16'(isc), 1'b0);
		wr(16'h2106, 16'(nsc), 1'b0);
		wr(16'h1204, 16'(mx), 1'b0);
		adc_u.send(1'b0, 16'(raw));
		wait_sp();
		v = clampi(clampi(raw, 10000) + off, 10000);
		v = (v <= win && v >= -win) ? 0 : v;
		check(reference_mv, 16'(v));
		check(current_setpoint, 16'(clampi(v * isc / 10000, 30000)));
		check(speed_setpoint, 16'(clampi(clampi(v * nsc / 10000, 30000), mx)));
		rd(16'h0902, 16'(v), 1'b0);
	endtask
	task automatic t_defaults();
		rd(16'h0912, 16'h0, 1'b0);
		rd(16'h0916, 16'h0, 1'b0);
		rd(16'h2006, 16'h012C, 1'b0);
		rd(16'h2106, 16'h0BB8, 1'b0);
		rd(16'h1204, 16'h3390, 1'b0);
		rd(16'h0100, 16'h0, 1'b1);
	endtask
	// window and lower offset boundary values pass; one past the window, offset, current scale and speed limits or below the speed scale minimum is refused
	task automatic t_refuse();
		wr(16'h0912, 16'h03E9, 1'b1);
		wr(16'h0912, 16'h03E8, 1'b0);
		wr(16'h0916, 16'h1389, 1'b1);
		wr(16'h0916, 16'hEC78, 1'b0);
		wr(16'h2006, 16'h7531, 1'b1);
		wr(16'h2106, 16'h8ACF, 1'b1);
		wr(16'h1204, 16'h3391, 1'b1);
		wr(16'h0902, 16'h0005, 1'b1);
		wr(16'h090A, 16'h0005, 1'b1);
		rd(16'h0912, 16'h03E8, 1'b0);
		rd(16'h0916, 16'hEC78, 1'b0);
	endtask
	task automatic t_path();
		run_case(5000, 0, 0, 300, 3000, 13200);
		run_case(30, -15, 20, 300, 3000, 13200);
		run_case(-10, 25, 20, 300, 3000, 13200);
		run_case(21, 0, 20, 300, 3000, 13200);
		run_case(12000, 5000, 0, -30000, 30000, 13200);
		run_case(-10000, -5000, 1000, 30000, -30000, 1000);
		run_case(-3333, 100, 0, -7, 3000, 13200);
	endtask
	// secondary samples skip offset and give no setpoint
	task automatic t_secondary();
		adc_u.send(1'b1, 16'hE2AC);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			check({15'h0, sp_valid}, 16'h0);
		end
		rd(16'h090A, 16'hE2AC, 1'b0);
		adc_u.send(1'b1, 16'h2AF8);
		repeat (8) @(posedge clk);
		rd(16'h090A, 16'h2710, 1'b0);
	endtask
	// stalled consumer fills the buffer, then all samples drain in order
	task automatic t_fifo();
		@(posedge clk);
		sp_ready <= 1'b0;
		for (int i = 1; i <= 20; i++)
			adc_u.send(1'b0, 16'(i * 100));
		repeat (40) @(posedge clk);
		#1;
		check({15'h0, adc_ready}, 16'h0);
		check(reference_mv, 16'(200));
		@(posedge clk);
		sp_ready <= 1'b1;
		for (int i = 2; i <= 20; i++) begin
			wait_sp();
			check(reference_mv, 16'(i * 100 + 100));
		end
		check({15'h0, adc_ready}, 16'h1);
	endtask
	task automatic results();
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// main sequence after an 8-cycle reset
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_defaults();
		t_refuse();
		t_path();
		t_secondary();
		t_fifo();
		results();
	end
	// watchdog: the sequence needs a few hundred cycles at most
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
endmodule
